// >>> rtl/ccr_consts.svh
// cache control register constants: code, field positions, reset, timing
// assumes inclusion by bare name from rtl files
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH
`define CCR_CODE        12'h002
`define CCR_RESET       32'h0000_0000
`define CCR_BIT_ENB     31
`define CCR_BIT_PDI     28
`define CCR_BIT_FRZ     27
`define CCR_BIT_INV     24
`define CCR_BIT_INSTR_CACHING_OFF    23
`define CCR_BIT_DATA_CACHING_OFF    22
`define CCR_BIT_INVALIDATE_INSTR_HALF    21
`define CCR_BIT_INVALIDATE_DATA_HALF    20
`define CCR_BIT_DCM     9
// writable bits: 31, 28, 27, 23..0 (30..29, 26..25 and 24 never stored)
`define CCR_KEEP_MASK   32'h98FF_FFFF
`define CCR_OVERHEAD    2
`define CCR_ENTRIES     128
`endif

// >>> rtl/ccr_pkg.sv
// types shared by the cache control register logic
// assumes ccr_consts.svh is on the include path
package ccr_pkg;
  // one control register move from the core or debug module
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        debug;
    logic [11:0] code;
    logic [31:0] data;
  } ccr_move_t;
  // invalidation sequencer states
  typedef enum logic [2:0] {
    CCR_IDLE = 3'b001,
    CCR_OVHD = 3'b010,
    CCR_CLR  = 3'b100
  } ccr_state_t;
endpackage

// >>> rtl/ccr_inval_seq.sv
// invalidate-all sequencer: clears one tag index per cycle
// assumes start is a one-cycle pulse taken only while idle
`timescale 1ns/10ps
`include "ccr_consts.svh"
module ccr_inval_seq #(
  parameter int ENTRIES  = `CCR_ENTRIES,
  parameter int OVERHEAD = `CCR_OVERHEAD
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // request: first index and entry count
  input  wire logic                       start,
  input  wire logic [$clog2(ENTRIES)-1:0] first,
  input  wire logic [$clog2(ENTRIES):0]   count,
  // tag clear strobe
  output logic                            busy,
  output logic                            clr_valid,
  output logic [$clog2(ENTRIES)-1:0]      clr_index
);
  import ccr_pkg::*;
  localparam int IW = $clog2(ENTRIES);
  ccr_state_t     state;
  logic [IW:0]    left;
  logic [7:0]     ovh;

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // overhead cycles first, then exactly one entry per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      state     <= CCR_IDLE;
      left      <= '0;
      ovh       <= 8'h00;
      clr_valid <= 1'b0;
      clr_index <= '0;
      busy      <= 1'b0;
    end else begin
      clr_valid <= 1'b0;
      case (state)
        CCR_IDLE: begin
          if (start && count != '0) begin
            state     <= CCR_OVHD;
            ovh       <= 8'(OVERHEAD);
            left      <= count;
            clr_index <= first;
            busy      <= 1'b1;
          end
        end
        CCR_OVHD: begin
          if (ovh <= 8'h01) begin
            state <= CCR_CLR;
          end else begin
            ovh <= ovh - 8'h01;
          end
        end
        CCR_CLR: begin
          clr_valid <= 1'b1;
          if (clr_valid) begin
            clr_index <= clr_index + IW'(1);
          end
          left <= left - (IW+1)'(1);
          if (left == (IW+1)'(1)) begin
            state <= CCR_IDLE;
          end
        end
        default: begin
          state <= CCR_IDLE;
        end
      endcase
      // busy drops once the final clear strobe is out
      if (state == CCR_IDLE && !(start && count != '0)) begin
        busy <= clr_valid;
      end
    end
  end
endmodule

// >>> rtl/ccr_ctrl.sv
// cache control register with invalidate and line-push control
// assumes moves arrive one per cycle and line pushes are privileged
// Operation
// - 32-bit write-only register written by control move, code 0x002.
// - debug reads return current register contents.
// - reset clears every register bit, cache disabled.
// - default attributes apply to addresses outside all access regions.
// - array enabled only while bit 31 is one; selects configuration.
// - line push invalidates entry addr[10:4] unless bit 28 set; dropped if a sequencer clear is out in the same cycle.
// - freeze still fills the line buffer, never overwrites valid entries.
// - freeze still lets the fill buffer write invalid entries.
// - invalidate-all works whether or not the cache is enabled.
// - invalidate clears all, half or none per disable and half bits.
// - one tag entry per cycle, 128 full, 64 half, plus overhead.
// - invalidate trigger never stored; always reads as zero.
// - bit 23 disables instruction, bit 22 data; both clear means split.
// - half-invalidate bits settable only in split configuration.
// - fetches held off until invalidation completes.
// - processor reads of the register return zeros.
`timescale 1ns/10ps
`include "ccr_consts.svh"
module ccr_ctrl #(
  parameter int ENTRIES  = `CCR_ENTRIES,
  parameter int OVERHEAD = `CCR_OVERHEAD
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // control register move port
  input  ccr_pkg::ccr_move_t              move,
  output logic                            rd_valid,
  output logic [31:0]                     rd_data,
  // line push request
  input  wire logic                       push_valid,
  input  wire logic [31:0]                push_addr,
  // fill buffer write request for one tag index
  input  wire logic                       fill_req,
  input  wire logic [$clog2(ENTRIES)-1:0] fill_index,
  input  wire logic                       fill_entry_valid,
  input  wire logic                       addr_in_region,
  // cache control outputs
  output logic                            array_enable,
  output logic                            instr_caching_off,
  output logic                            data_caching_off,
  output logic                            default_noncache,
  output logic                            fill_allow,
  output logic                            fetch_hold,
  output logic                            tag_clr_valid,
  output logic [$clog2(ENTRIES)-1:0]      tag_clr_index
);
  import ccr_pkg::*;
  localparam int IW = $clog2(ENTRIES);

  logic [31:0]   cache_control;
  logic          seq_busy;
  logic          seq_clr;
  logic [IW-1:0] seq_idx;
  logic          inv_go;
  logic [IW-1:0] inv_first;
  logic [IW:0]   inv_count;
  logic [31:0]   next_cache_control;

  // address decode shared by reads and writes
  function automatic logic hits(input ccr_move_t m);
    return m.valid && m.code == `CCR_CODE;
  endfunction

  // ----------------------------------------------------------------
  // register write
  // ----------------------------------------------------------------
  // trigger and reserved bits are masked off; half bits need split
  always_comb begin
    next_cache_control = move.data & `CCR_KEEP_MASK;
    if (move.data[`CCR_BIT_INSTR_CACHING_OFF] || move.data[`CCR_BIT_DATA_CACHING_OFF]) begin
      next_cache_control[`CCR_BIT_INVALIDATE_INSTR_HALF] = 1'b0;
      next_cache_control[`CCR_BIT_INVALIDATE_DATA_HALF] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cache_control <= `CCR_RESET;
    end else if (hits(move) && move.write) begin
      cache_control <= next_cache_control;
    end
  end

  // ----------------------------------------------------------------
  // invalidate-all decode
  // ----------------------------------------------------------------
  // split: top index bit (address bit 10) picks half; half bits narrow the range
  always_comb begin
    inv_go    = hits(move) && move.write && move.data[`CCR_BIT_INV];
    inv_first = '0;
    inv_count = (IW+1)'(ENTRIES);
    if (!next_cache_control[`CCR_BIT_INSTR_CACHING_OFF] && !next_cache_control[`CCR_BIT_DATA_CACHING_OFF]) begin
      case ({next_cache_control[`CCR_BIT_INVALIDATE_INSTR_HALF], next_cache_control[`CCR_BIT_INVALIDATE_DATA_HALF]})
        2'b10: begin
          inv_count = (IW+1)'(ENTRIES / 2);
        end
        2'b01: begin
          inv_first = IW'(ENTRIES / 2);
          inv_count = (IW+1)'(ENTRIES / 2);
        end
        2'b11: begin
          inv_count = '0;
        end
        default: begin
          inv_count = (IW+1)'(ENTRIES);
        end
      endcase
    end
  end

  ccr_inval_seq #(
    .ENTRIES  (ENTRIES),
    .OVERHEAD (OVERHEAD)
  ) u_seq (
    .clk       (clk),
    .rst       (rst),
    .start     (inv_go && !seq_busy),
    .first     (inv_first),
    .count     (inv_count),
    .busy      (seq_busy),
    .clr_valid (seq_clr),
    .clr_index (seq_idx)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // only debug reads see contents; processor reads see zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data  <= 32'h0000_0000;
    end else begin
      rd_valid <= hits(move) && !move.write;
      if (hits(move) && !move.write && move.debug) begin
        rd_data <= cache_control;
      end else begin
        rd_data <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // cache controls
  // ----------------------------------------------------------------
  // a line push shares the clear port; sequencer clears take priority
  always_ff @(posedge clk) begin
    if (rst) begin
      array_enable      <= 1'b0;
      instr_caching_off <= 1'b0;
      data_caching_off  <= 1'b0;
      default_noncache  <= 1'b0;
      fill_allow        <= 1'b0;
      fetch_hold        <= 1'b0;
      tag_clr_valid     <= 1'b0;
      tag_clr_index     <= '0;
    end else begin
      array_enable      <= cache_control[`CCR_BIT_ENB];
      instr_caching_off <= cache_control[`CCR_BIT_INSTR_CACHING_OFF];
      data_caching_off  <= cache_control[`CCR_BIT_DATA_CACHING_OFF];
      default_noncache  <= !addr_in_region && cache_control[`CCR_BIT_DCM];
      // freeze keeps valid lines; invalid lines still take the fill
      fill_allow        <= fill_req && cache_control[`CCR_BIT_ENB] &&
                           (!cache_control[`CCR_BIT_FRZ] || !fill_entry_valid);
      fetch_hold        <= seq_busy || (inv_go && inv_count != '0);
      if (seq_clr) begin
        tag_clr_valid <= 1'b1;
        tag_clr_index <= seq_idx;
      end else begin
        tag_clr_valid <= push_valid && !cache_control[`CCR_BIT_PDI];
        tag_clr_index <= push_addr[IW+3:4];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_reset_clear;
    @(posedge clk) rst |=> cache_control == 32'h0000_0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left register set");

  property p_trigger_zero;
    @(posedge clk) disable iff (rst) !cache_control[`CCR_BIT_INV];
  endproperty
  a_trigger_zero: assert property (p_trigger_zero) else $error("trigger bit stored");

  property p_cpu_read_zero;
    @(posedge clk) disable iff (rst)
      hits(move) && !move.write && !move.debug |=> rd_valid && rd_data == 32'h0;
  endproperty
  a_cpu_read_zero: assert property (p_cpu_read_zero) else $error("cpu read not zero");

  property p_debug_read;
    @(posedge clk) disable iff (rst)
      hits(move) && !move.write && move.debug |=> rd_data == $past(cache_control);
  endproperty
  a_debug_read: assert property (p_debug_read) else $error("debug read mismatch");

  property p_enable_follows;
    @(posedge clk) disable iff (rst) ##1 array_enable == $past(cache_control[31]);
  endproperty
  a_enable_follows: assert property (p_enable_follows) else $error("enable mismatch");

  property p_push_inval;
    @(posedge clk) disable iff (rst)
      push_valid && !seq_clr && !cache_control[28] |=>
        tag_clr_valid && tag_clr_index == $past(push_addr[10:4]);
  endproperty
  a_push_inval: assert property (p_push_inval) else $error("line push not cleared");

  property p_push_off;
    @(posedge clk) disable iff (rst)
      push_valid && !seq_clr && cache_control[28] |=> !tag_clr_valid;
  endproperty
  a_push_off: assert property (p_push_off) else $error("line push acted while off");

  property p_freeze;
    @(posedge clk) disable iff (rst)
      cache_control[27] && fill_entry_valid |=> !fill_allow;
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen valid line overwritten");

  property p_freeze_invalid;
    @(posedge clk) disable iff (rst)
      fill_req && cache_control[31] && !fill_entry_valid |=> fill_allow;
  endproperty
  a_freeze_invalid: assert property (p_freeze_invalid) else $error("invalid fill refused");

  property p_full_inval;
    @(posedge clk) disable iff (rst)
      inv_go && !seq_busy && inv_count == 8'd128 |=> fetch_hold [*8];
  endproperty
  a_full_inval: assert property (p_full_inval) else $error("fetch not held");

  property p_split_half;
    @(posedge clk) disable iff (rst)
      hits(move) && move.write && (move.data[23] || move.data[22]) |=>
        !cache_control[21] && !cache_control[20];
  endproperty
  a_split_half: assert property (p_split_half) else $error("half bit set outside split");

  property p_hold_during_clear;
    @(posedge clk) disable iff (rst) seq_clr |=> fetch_hold;
  endproperty
  a_hold_during_clear: assert property (p_hold_during_clear) else $error("hold dropped");
endmodule

// >>> tb/ccr_core_model.sv
// core model: issues control register moves and line pushes
// assumes the bench calls its tasks; drives only on falling edges
`timescale 1ns/10ps
module ccr_core_model (
  // clock
  input  wire logic          clk,
  // requests toward the block
  output ccr_pkg::ccr_move_t move,
  output logic               push_valid,
  output logic [31:0]        push_addr
);
  import ccr_pkg::*;
  // idle bus at time zero
  initial begin
    move       = '0;
    push_valid = 1'b0;
    push_addr  = 32'h0;
  end
  // one move; reserved 30..29 and 26..25 always written as zero
  task automatic issue(input logic wr, input logic dbg, input logic [11:0] code,
                       input logic [31:0] d);
    @(negedge clk);
    move <= '{1'b1, wr, dbg, code, d & 32'h99FF_FFFF};
    @(negedge clk);
    move.valid <= 1'b0;
    move.data  <= ~(d & 32'h99FF_FFFF); // released bus must not keep its value
  endtask
  // one line push of a single cycle
  task automatic push(input logic [31:0] a);
    @(negedge clk);
    push_valid <= 1'b1;
    push_addr  <= a;
    @(negedge clk);
    push_valid <= 1'b0;
    push_addr  <= ~a;
  endtask
endmodule

// >>> tb/tb_ccr_ctrl.sv
// testbench for the cache control register logic
// assumes the core model drives moves; results are checked from queues
`timescale 1ns/10ps
module tb_ccr_ctrl;
  import ccr_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  ccr_move_t   move;
  logic        push_valid, rd_valid, fill_req, fill_entry_valid, addr_in_region;
  logic [31:0] push_addr, rd_data, d, e;
  logic [6:0]  fill_index, tag_clr_index;
  logic        array_enable, instr_caching_off, data_caching_off, default_noncache;
  logic        fill_allow, fetch_hold, tag_clr_valid;
  logic [31:0] exp_rd[$];
  logic [31:0] exp_clr[$];
  int          mismatches = 0;
  int          check_count = 0;
  logic [31:0] inv_d [5] = '{32'h0100_0000, 32'h0120_0000, 32'h0110_0000,
                             32'h0130_0000, 32'h0160_0000};
  int          inv_f [5] = '{0, 0, 64, 0, 0};
  int          inv_n [5] = '{128, 64, 64, 0, 128};
  always #25 clk = ~clk;
  ccr_core_model core (.clk(clk), .move(move), .push_valid(push_valid),
                       .push_addr(push_addr));
  ccr_ctrl #(.ENTRIES(128), .OVERHEAD(2)) u_dut (
    .clk(clk), .rst(rst), .move(move), .rd_valid(rd_valid), .rd_data(rd_data),
    .push_valid(push_valid), .push_addr(push_addr), .fill_req(fill_req),
    .fill_index(fill_index), .fill_entry_valid(fill_entry_valid),
    .addr_in_region(addr_in_region), .array_enable(array_enable),
    .instr_caching_off(instr_caching_off), .data_caching_off(data_caching_off),
    .default_noncache(default_noncache), .fill_allow(fill_allow),
    .fetch_hold(fetch_hold), .tag_clr_valid(tag_clr_valid),
    .tag_clr_index(tag_clr_index));
  // one comparison, counted
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // monitor: each result takes the oldest note; an empty queue shows as ones
  always @(negedge clk) begin
    if (rd_valid === 1'b1)
      check(rd_data, exp_rd.size() > 0 ? exp_rd.pop_front() : 32'hFFFF_FFFF);
    if (tag_clr_valid === 1'b1)
      check(32'(tag_clr_index), exp_clr.size() > 0 ? exp_clr.pop_front() : 32'hFFFF_FFFF);
  end
  // invalidate-all sweep of n entries from index f, bounded wait
  task automatic inval(input logic [31:0] v, input int f, input int n);
    int k;
    for (k = f; k < f + n; k++) exp_clr.push_back(32'(k));
    core.issue(1'b1, 1'b0, 12'h002, v);
    repeat (2) @(negedge clk);
    check(32'(fetch_hold), 32'(n > 0));
    k = 0;
    while (fetch_hold !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    // one entry per cycle: never faster than n, only a few cycles of overhead
    if (n > 0) check(32'(k >= n && k <= n + 8), 32'h1);
    repeat (4) @(negedge clk);
    // a hold that never drops must count, not just end the wait
    check(32'(fetch_hold), 32'h0);
    check(32'(exp_clr.size()), 32'h0);
  endtask
  // watchdog: the run needs well under 10000 cycles
  initial begin
    #1_000_000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hD735BD8F));
    {fill_req, fill_entry_valid, addr_in_region, fill_index} = '0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // register clear after reset
    exp_rd.push_back(32'h0);
    core.issue(1'b0, 1'b1, 12'h002, 32'h0);
    // sweeps before any enable, enable bit clear throughout
    for (int i = 0; i < 5; i++) inval(inv_d[i], inv_f[i], inv_n[i]);
    exp_rd.push_back(32'h0040_0000);
    core.issue(1'b0, 1'b1, 12'h002, 32'h0);
    // random writes, readback, levels, freeze and default mode
    for (int i = 0; i < 8; i++) begin
      d = $urandom() & 32'hFEFF_FFFF;
      d[31] = (i != 5);
      d[27] = i[0];
      fill_entry_valid = i[1];
      fill_req = 1'($urandom());
      addr_in_region = 1'($urandom());
      fill_index = 7'($urandom());
      e = d & 32'h98FF_FFFF;
      if (d[23] | d[22]) e[21:20] = 2'b00;
      core.issue(1'b1, 1'b0, 12'h002, d);
      repeat (2) @(negedge clk);
      check(32'(array_enable), 32'(d[31]));
      check({instr_caching_off, data_caching_off}, d[23:22]);
      check(32'(default_noncache), 32'(~addr_in_region & d[9]));
      check(32'(fill_allow), 32'(fill_req & d[31] & (~d[27] | ~fill_entry_valid)));
      exp_rd.push_back(e);
      core.issue(1'b0, 1'b1, 12'h002, 32'h0);
      exp_rd.push_back(32'h0);
      core.issue(1'b0, 1'b0, 12'h002, 32'h0);
      core.issue(1'b1, 1'b0, 12'h004, ~d);
      exp_rd.push_back(e);
      core.issue(1'b0, 1'b1, 12'h002, 32'h0);
    end
    // full sweep while the cache is enabled
    inval(32'h8100_0000, 0, 128);
    // line push with invalidation on, then off
    core.issue(1'b1, 1'b0, 12'h002, 32'h0);
    d = $urandom();
    exp_clr.push_back(32'(d[10:4]));
    core.push(d);
    core.issue(1'b1, 1'b0, 12'h002, 32'h1000_0000);
    core.push(~d);
    repeat (8) @(negedge clk);
    check(32'(exp_clr.size() + exp_rd.size()), 32'h0);
    tally_and_finish();
  end
endmodule
